// ==== shared/ascc_defs.svh ====
// register map, reset values and timing counts of the converter control block
`ifndef ASCC_DEFS_SVH
`define ASCC_DEFS_SVH
`define ASCC_ADDR_CFG      12'h000
`define ASCC_ADDR_CMD      12'h004
`define ASCC_ADDR_STAT     12'h008
`define ASCC_ADDR_CSR0     12'h010
`define ASCC_CFG_RESET     24'h000040
`define ASCC_CSR_RESET     24'h000000
`define ASCC_CFG_WMASK     24'h37FF80
`define ASCC_CFG_RS_POS    7
`define ASCC_CMD_START_POS 0
`define ASCC_CMD_STOP_POS  1
`define ASCC_CMD_READ_POS  2
`define ASCC_CMD_SETUP_LSB 4
`define ASCC_CLK_HZ        64'd125000000
`define ASCC_WAKE_MS       64'd500
`define ASCC_WAKE_CYC      ((`ASCC_WAKE_MS * `ASCC_CLK_HZ) / 64'd1000)
`define ASCC_SYSRST_CYC    32'd8
`define ASCC_RATE0_CYC     32'd2180
`define ASCC_RATE1_CYC     32'd1092
`define ASCC_RATE2_CYC     32'd532
`define ASCC_RATE3_CYC     32'd388
`define ASCC_RATE4_CYC     32'd324
`define ASCC_RATE5_CYC     17444
`define ASCC_RATE6_CYC     8724
`define ASCC_RATE7_CYC     4364
`define ASCC_CHOP0_HALF    7'd64
`define ASCC_CHOP1_HALF    7'd4
`define ASCC_CHOP2_HALF    7'd1
`define ASCC_CHOP3_HALF    7'd16
`endif

// ==== shared/ascc_pkg.sv ====
// types of the converter control block
package ascc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CONVERT, ST_WAIT_READ, ST_SAVE, ST_WAKE, ST_SYSRST
    } ascc_phase_type;

    typedef struct packed {
        logic [1:0] nu_hi;
        logic [1:0] chop_rate_sel;
        logic       nu_mid;
        logic       multi_setup_bit;
        logic       loop_bit;
        logic       wait_for_read_bit;
        logic [3:0] setup_depth;
        logic       save_depth_sel;
        logic       pump_disable_bit;
        logic       save_run_bit;
        logic       reduced_power_bit;
        logic       sys_reset_bit;
        logic       reset_done_flag;
        logic       oscillation_flag;
        logic       overflow_flag;
        logic [3:0] nu_lo;
    } ascc_cfg_type;

    typedef struct packed {
        logic [1:0] latch_out_pins;
        logic [2:0] channel_sel;
        logic [2:0] rate_sel;
        logic [2:0] gain_sel;
        logic       unipolar;
    } ascc_setup_type;

    typedef struct packed {
        logic       start;
        logic [2:0] channel_sel;
        logic [2:0] rate_sel;
        logic [2:0] gain_sel;
        logic       unipolar;
        logic [1:0] chop_rate_sel;
        logic       chop_clk;
        logic       reduced_power;
        logic       power_save;
        logic       osc_enable;
    } ascc_conv_ctrl_type;

    typedef struct packed {
        logic above_fs;
        logic below_zero;
        logic below_neg_fs;
    } ascc_conv_in_type;
endpackage

// ==== rtl/ascc_top.sv ====
// converter setup, configuration and sequencing control with APB registers
`timescale 1ns/1ps
`include "ascc_defs.svh"
module ascc_top #(
    parameter int          NCSR      = 4,
    parameter int unsigned WAKE_CYC  = 32'(`ASCC_WAKE_CYC),
    parameter int unsigned RATE5_CYC = `ASCC_RATE5_CYC,
    parameter int unsigned RATE6_CYC = `ASCC_RATE6_CYC,
    parameter int unsigned RATE7_CYC = `ASCC_RATE7_CYC,
    parameter int          PUMP_W    = 2
) (
    // clock and reset
    input  wire logic                        CLK,
    input  wire logic                        SYS_RST,
    // apb slave
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [11:0]                 PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic      [31:0]                 PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    // converter front end
    output ascc_pkg::ascc_conv_ctrl_type     CONV_CTRL,
    input  wire ascc_pkg::ascc_conv_in_type  CONV_IN,
    input  wire logic                        MOD_OSC,
    output logic                             DATA_READY,
    output logic                             DATA_PENDING,
    // pins
    output logic      [1:0]                  LATCH_OUT_PINS,
    output logic                             PUMP_DRIVE_PIN_O,
    output logic                             PUMP_DRIVE_PIN_OE
);
    import ascc_pkg::*;

    localparam int NSETUP = 2 * NCSR;

    typedef struct packed {
        ascc_phase_type          state;
        ascc_cfg_type            cfg;
        logic [NCSR-1:0][23:0]   csr;
        logic [3:0]              cur;
        logic [31:0]             cnt;
        logic                    osc_stopped;
        logic                    pending;
        logic                    start;
        logic                    ready;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic [6:0]              chop_cnt;
        logic                    chop;
        logic [PUMP_W-1:0]       pump_cnt;
        logic [2:0]              sync;
    } ascc_state_type;

    ascc_state_type s;
    ascc_state_type next_s;

    // setup idx: even index in upper half of its register
    function automatic ascc_setup_type setup_f(input logic [NCSR-1:0][23:0] csr,
                                               input logic [3:0] idx);
        logic [23:0] w;
        w = '0;
        if (int'(idx[3:1]) < NCSR) begin
            w = csr[idx[3:1]];
        end
        return idx[0] ? ascc_setup_type'(w[11:0]) : ascc_setup_type'(w[23:12]);
    endfunction

    function automatic logic [31:0] rate_cyc(input logic [2:0] sel);
        unique case (sel)
            3'h0: return `ASCC_RATE0_CYC;
            3'h1: return `ASCC_RATE1_CYC;
            3'h2: return `ASCC_RATE2_CYC;
            3'h3: return `ASCC_RATE3_CYC;
            3'h4: return `ASCC_RATE4_CYC;
            3'h5: return 32'(RATE5_CYC);
            3'h6: return 32'(RATE6_CYC);
            3'h7: return 32'(RATE7_CYC);
        endcase
    endfunction

    function automatic logic is_csr(input logic [11:0] a);
        return a >= `ASCC_ADDR_CSR0 && a < `ASCC_ADDR_CSR0 + 12'(4 * NCSR)
               && a[1:0] == 2'h0;
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        return a == `ASCC_ADDR_CFG || a == `ASCC_ADDR_CMD
               || a == `ASCC_ADDR_STAT || is_csr(a);
    endfunction

    ascc_setup_type act;
    assign act = setup_f(s.csr, s.cur);

    logic acc;
    logic wr;
    logic rd;
    assign acc = PSEL && PENABLE;
    assign wr  = acc && s.pready && PWRITE && !s.pslverr;
    assign rd  = acc && s.pready && !PWRITE && !s.pslverr;

    always_comb begin
        logic           go;
        logic           over;
        logic [3:0]     last;
        logic [3:0]     csr_i;
        logic [6:0]     half;
        ascc_setup_type sp;
        logic           rs_wr;
        go    = 1'b0;
        over  = 1'b0;
        rs_wr = wr && PADDR == `ASCC_ADDR_CFG && PWDATA[`ASCC_CFG_RS_POS];
        csr_i = 4'((PADDR - `ASCC_ADDR_CSR0) >> 2);
        last  = (int'(s.cfg.setup_depth) < NSETUP) ? s.cfg.setup_depth
                                                    : 4'(NSETUP - 1);
        sp    = act;
        half  = `ASCC_CHOP0_HALF;
        next_s       = s;
        next_s.start = 1'b0;
        next_s.ready = 1'b0;
        next_s.sync  = {s.sync[1:0], MOD_OSC};

        // one wait state so read data leaves a flip-flop
        next_s.pready  = acc && !s.pready;
        next_s.pslverr = acc && !s.pready && !addr_ok(PADDR);
        if (acc && !s.pready && !PWRITE) begin
            next_s.prdata = 32'h00000000;
            if (PADDR == `ASCC_ADDR_CFG) begin
                next_s.prdata = {8'h00, s.cfg};
            end else if (PADDR == `ASCC_ADDR_STAT) begin
                next_s.prdata = {22'h000000, s.osc_stopped, s.pending,
                                 s.cur, 1'b0, s.state};
            end else if (is_csr(PADDR)) begin
                next_s.prdata = {8'h00, s.csr[csr_i]};
            end
        end

        // configuration writes
        if (wr && PADDR == `ASCC_ADDR_CFG) begin
            if (s.cfg.sys_reset_bit) begin
                next_s.cfg.sys_reset_bit = PWDATA[`ASCC_CFG_RS_POS];
            end else begin
                next_s.cfg = ascc_cfg_type'((PWDATA[23:0] & `ASCC_CFG_WMASK)
                             | (s.cfg & ~`ASCC_CFG_WMASK));
            end
        end
        if (wr && is_csr(PADDR) && s.state != ST_SYSRST) begin
            next_s.csr[csr_i] = PWDATA[23:0];
        end
        if (wr && PADDR == `ASCC_ADDR_CMD && PWDATA[`ASCC_CMD_READ_POS]) begin
            next_s.pending = 1'b0;
        end
        if (rd && PADDR == `ASCC_ADDR_CFG) begin
            next_s.cfg.reset_done_flag = 1'b0;
        end

        // oscillation flag counts once the last two sync stages agree
        if (s.sync[1] == s.sync[2]) begin
            next_s.cfg.oscillation_flag = s.sync[2];
        end

        unique case (s.state)
            ST_IDLE: begin
                if (wr && PADDR == `ASCC_ADDR_CMD && PWDATA[`ASCC_CMD_START_POS]
                    && !s.cfg.sys_reset_bit) begin
                    next_s.cur = s.cfg.multi_setup_bit ? 4'h0
                               : PWDATA[`ASCC_CMD_SETUP_LSB +: 4];
                    go = 1'b1;
                end
            end
            ST_CONVERT: begin
                next_s.cnt = s.cnt - 32'd1;
                if (s.cnt == 32'd0) begin
                    // range check depends on the setup polarity
                    over = CONV_IN.above_fs || (sp.unipolar ? CONV_IN.below_zero
                                                            : CONV_IN.below_neg_fs);
                    next_s.cfg.overflow_flag = over;
                    next_s.ready   = 1'b1;
                    next_s.pending = 1'b1;
                    next_s.state   = ST_IDLE;
                    if (s.cfg.multi_setup_bit && s.cur < last) begin
                        next_s.cur = s.cur + 4'h1;
                        go = 1'b1;
                    end else if (s.cfg.loop_bit) begin
                        if (s.cur != 4'h0 && s.cfg.multi_setup_bit) begin
                            next_s.cur = 4'h0;
                        end
                        if (s.cfg.wait_for_read_bit) begin
                            next_s.state = ST_WAIT_READ;
                        end else begin
                            go = 1'b1;
                        end
                    end
                end
            end
            ST_WAIT_READ: begin
                if (!next_s.pending) begin
                    go = 1'b1;
                end
            end
            ST_SAVE: begin
                next_s.osc_stopped = s.cfg.save_depth_sel;
                if (!s.cfg.save_run_bit) begin
                    next_s.osc_stopped = 1'b0;
                    next_s.state = s.osc_stopped ? ST_WAKE : ST_IDLE;
                    next_s.cnt   = 32'(WAKE_CYC) - 32'd1;
                end
            end
            ST_WAKE: begin
                next_s.cnt = s.cnt - 32'd1;
                if (s.cnt == 32'd0) begin
                    next_s.state = ST_IDLE;
                end
            end
            ST_SYSRST: begin
                // a fresh reset write restarts the count further down
                if (!rs_wr) begin
                    next_s.cnt = s.cnt - 32'd1;
                    if (s.cnt == 32'd0) begin
                        next_s.cfg.reset_done_flag = 1'b1;
                        next_s.state = ST_IDLE;
                    end
                end
            end
        endcase

        if (wr && PADDR == `ASCC_ADDR_CMD && PWDATA[`ASCC_CMD_STOP_POS]
            && (s.state == ST_CONVERT || s.state == ST_WAIT_READ)) begin
            next_s.state = ST_IDLE;
            go = 1'b0;
        end
        if (go) begin
            next_s.state = ST_CONVERT;
            next_s.cnt   = rate_cyc(setup_f(s.csr, next_s.cur).rate_sel) - 32'd1;
            next_s.start = 1'b1;
        end
        if (s.cfg.save_run_bit && next_s.state != ST_SYSRST
            && s.state != ST_SYSRST) begin
            next_s.state = ST_SAVE;
            next_s.start = 1'b0;
        end
        // a reset write wins over any conversion or power step in flight
        if (rs_wr) begin
            next_s.cfg = ascc_cfg_type'(`ASCC_CFG_RESET);
            next_s.cfg.sys_reset_bit   = 1'b1;
            next_s.cfg.reset_done_flag = 1'b0;
            next_s.csr         = {NCSR{`ASCC_CSR_RESET}};
            next_s.state       = ST_SYSRST;
            next_s.cnt         = `ASCC_SYSRST_CYC - 32'd1;
            next_s.cur         = 4'h0;
            next_s.pending     = 1'b0;
            next_s.ready       = 1'b0;
            next_s.start       = 1'b0;
            next_s.osc_stopped = 1'b0;
        end

        // chop clock halts with the analog section
        unique case (s.cfg.chop_rate_sel)
            2'h0: half = `ASCC_CHOP0_HALF;
            2'h1: half = `ASCC_CHOP1_HALF;
            2'h2: half = `ASCC_CHOP2_HALF;
            2'h3: half = `ASCC_CHOP3_HALF;
        endcase
        if (s.state != ST_SAVE && s.state != ST_WAKE) begin
            next_s.chop_cnt = s.chop_cnt + 7'd1;
            if (s.chop_cnt >= half - 7'd1) begin
                next_s.chop_cnt = 7'd0;
                next_s.chop     = !s.chop;
            end
        end
        if (!s.cfg.pump_disable_bit && !s.osc_stopped) begin
            next_s.pump_cnt = s.pump_cnt + PUMP_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s     <= '0;
            s.cfg <= `ASCC_CFG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign PRDATA  = s.prdata;
    assign PREADY  = s.pready;
    assign PSLVERR = s.pslverr;
    assign DATA_READY   = s.ready;
    assign DATA_PENDING = s.pending;
    assign LATCH_OUT_PINS = act.latch_out_pins;
    assign PUMP_DRIVE_PIN_O  = s.pump_cnt[PUMP_W-1];
    assign PUMP_DRIVE_PIN_OE = !s.cfg.pump_disable_bit;
    always_comb begin
        CONV_CTRL.start         = s.start;
        CONV_CTRL.channel_sel   = act.channel_sel;
        CONV_CTRL.rate_sel      = act.rate_sel;
        CONV_CTRL.gain_sel      = act.gain_sel;
        CONV_CTRL.unipolar      = act.unipolar;
        CONV_CTRL.chop_rate_sel = s.cfg.chop_rate_sel;
        CONV_CTRL.chop_clk      = s.chop;
        CONV_CTRL.reduced_power = s.cfg.reduced_power_bit;
        CONV_CTRL.power_save    = s.state == ST_SAVE || s.state == ST_WAKE;
        CONV_CTRL.osc_enable    = !s.osc_stopped;
    end

    sequence s_cfg_wr;
        wr && PADDR == `ASCC_ADDR_CFG;
    endsequence
    sequence s_conv_end;
        s.state == ST_CONVERT && s.cnt == 32'd0;
    endsequence

    property p_latch;
        @(posedge CLK) disable iff (SYS_RST)
        wr && PADDR == `ASCC_ADDR_CSR0 && s.cur == 4'h0 && s.state != ST_SYSRST
        |=> s.cur != 4'h0 || LATCH_OUT_PINS == $past(PWDATA[23:22]);
    endproperty
    a_latch: assert property (p_latch) else $error("latch pins not updated");

    property p_rate_reset;
        @(posedge CLK) disable iff (SYS_RST)
        $fell(SYS_RST) |-> CONV_CTRL.rate_sel == 3'h0 && s.cfg == `ASCC_CFG_RESET;
    endproperty
    a_rate_reset: assert property (p_rate_reset) else $error("bad reset state");

    property p_sysrst;
        @(posedge CLK) disable iff (SYS_RST)
        s_cfg_wr ##0 PWDATA[`ASCC_CFG_RS_POS]
        |=> s.state == ST_SYSRST && !s.cfg.reset_done_flag ##8 s.cfg.reset_done_flag;
    endproperty
    a_sysrst: assert property (p_sysrst) else $error("reset cycle wrong");

    property p_rv_clear;
        @(posedge CLK) disable iff (SYS_RST)
        rd && PADDR == `ASCC_ADDR_CFG && s.state != ST_SYSRST |=> !s.cfg.reset_done_flag;
    endproperty
    a_rv_clear: assert property (p_rv_clear) else $error("done flag not cleared");

    property p_rs_only;
        @(posedge CLK) disable iff (SYS_RST)
        s_cfg_wr ##0 s.cfg.sys_reset_bit && !PWDATA[`ASCC_CFG_RS_POS]
        |=> $stable(s.cfg.setup_depth) && $stable(s.cfg.chop_rate_sel) && !s.cfg.sys_reset_bit;
    endproperty
    a_rs_only: assert property (p_rs_only) else $error("write leaked in reset");

    property p_overflow;
        @(posedge CLK) disable iff (SYS_RST)
        s_conv_end ##0 CONV_IN.above_fs && !wr |=> s.cfg.overflow_flag && DATA_READY;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_step;
        @(posedge CLK) disable iff (SYS_RST)
        s_conv_end ##0 s.cfg.multi_setup_bit && s.cur == 4'h0 && s.cfg.setup_depth != 4'h0
        && !s.cfg.save_run_bit && !wr |=> s.cur == 4'h1 && CONV_CTRL.start;
    endproperty
    a_step: assert property (p_step) else $error("setup did not advance");

    property p_osc;
        @(posedge CLK) disable iff (SYS_RST)
        s.sync[1] && s.sync[2] && !(wr && PADDR == `ASCC_ADDR_CFG)
        |=> s.cfg.oscillation_flag;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillation flag missing");

    property p_save;
        @(posedge CLK) disable iff (SYS_RST)
        s.cfg.save_run_bit && s.state != ST_SYSRST && !(wr && PADDR == `ASCC_ADDR_CFG)
        |=> CONV_CTRL.power_save;
    endproperty
    a_save: assert property (p_save) else $error("power save not entered");

    property p_pump;
        @(posedge CLK) disable iff (SYS_RST)
        s_cfg_wr ##0 !s.cfg.sys_reset_bit && PWDATA[10] && !PWDATA[`ASCC_CFG_RS_POS]
        |=> !PUMP_DRIVE_PIN_OE [*2];
    endproperty
    a_pump: assert property (p_pump) else $error("pump pin still driven");
endmodule

// ==== dv/ascc_front_model.sv ====
// behavioural converter front end answering the control block
`timescale 1ns/1ps
module ascc_front_model (
    // clock
    input  wire logic                         clk,
    // control from the block, requests from the bench
    input  wire ascc_pkg::ascc_conv_ctrl_type ctrl,
    input  wire logic                         over_req,
    input  wire logic                         osc_req,
    // answers to the block
    output ascc_pkg::ascc_conv_in_type        conv_in,
    output logic                              mod_osc
);
    import ascc_pkg::*;
    // range result is fixed at conversion start and held to its end
    always @(posedge clk) begin
        if (ctrl.start === 1'b1) begin
            conv_in <= '{above_fs: over_req, below_zero: 1'b0, below_neg_fs: 1'b0};
        end
    end
    // a stopped oscillator leaves the modulator quiet
    assign mod_osc = osc_req & ctrl.osc_enable;
endmodule

// ==== dv/test_adc_setup_config_control.sv ====
// register and sequencing tests of the converter control block
`timescale 1ns/1ps
`include "ascc_defs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module test_adc_setup_config_control;
    import ascc_pkg::*;
    logic               clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, rdv;
    logic               pready, pslverr, err, data_ready, data_pending, pump_o, pump_oe;
    logic               over_req = 0, osc_req = 0, mod_osc, ck;
    logic [1:0]         latch;
    ascc_conv_ctrl_type conv_ctrl;
    ascc_conv_in_type   conv_in;
    int                 bad_count = 0, n_checks = 0, n, c;
    ascc_top #(.WAKE_CYC(20), .RATE5_CYC(50), .RATE6_CYC(50), .RATE7_CYC(50)) ascc_top_i (
        .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CONV_CTRL(conv_ctrl), .CONV_IN(conv_in), .MOD_OSC(mod_osc), .DATA_READY(data_ready),
        .DATA_PENDING(data_pending), .LATCH_OUT_PINS(latch), .PUMP_DRIVE_PIN_O(pump_o),
        .PUMP_DRIVE_PIN_OE(pump_oe));
    ascc_front_model ascc_front_model_i (.clk(clk), .ctrl(conv_ctrl), .over_req(over_req),
        .osc_req(osc_req), .conv_in(conv_in), .mod_osc(mod_osc));
    initial forever #4 clk = ~clk;
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin bad_count++; close_out(); end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
    function automatic logic sig(input int k);
        return (k == 0) ? data_ready : conv_ctrl.start;
    endfunction
    // wait for a pulse, n counts the edges taken
    task automatic wait_sig(input int k, input int lim);
        n = 0;
        do begin @(posedge clk); n++; end while (sig(k) !== 1'b1 && n < lim);
        if (n >= lim) begin bad_count++; close_out(); end
    endtask
    task automatic done(input string s); $display("test %s done", s); endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ASCC_ADDR_CFG);  `CHK("cfg reset", 32'h00000040, rdv)
        rd(`ASCC_ADDR_CFG);  `CHK("done cleared", 32'h00000000, rdv)
        rd(`ASCC_ADDR_CSR0); `CHK("csr reset", 32'h00000000, rdv)
        `CHK("rate reset", 3'h0, conv_ctrl.rate_sel)
        done("reset");
        wr(`ASCC_ADDR_CSR0, 32'h0098B000);
        rd(`ASCC_ADDR_CSR0); `CHK("csr rw", 32'h0098B000, rdv)
        `CHK("latch", 2'h2, latch)
        `CHK("chan", 3'h3, conv_ctrl.channel_sel)
        `CHK("gain", 3'h5, conv_ctrl.gain_sel)
        `CHK("polarity", 1'b1, conv_ctrl.unipolar)
        over_req <= 1'b1;
        wr(`ASCC_ADDR_CMD, 32'h00000001);
        wait_sig(1, 20); wait_sig(0, 2300);
        `CHK("rate0 span", 1'b1, n >= 2180 && n <= 2182)
        over_req <= 1'b0;
        rd(`ASCC_ADDR_CFG);  `CHK("over set", 1'b1, rdv[4])
        wr(`ASCC_ADDR_CMD, 32'h00000005);
        wait_sig(0, 2300);
        rd(`ASCC_ADDR_CFG);  `CHK("over clear", 1'b0, rdv[4])
        done("setup fields");
        wr(`ASCC_ADDR_CSR0, 32'h009CB6C4);
        wr(`ASCC_ADDR_CFG, 32'h00041000);
        wr(`ASCC_ADDR_CMD, 32'h00000005);
        wait_sig(1, 20); `CHK("first setup", 3'h3, conv_ctrl.channel_sel)
        wait_sig(1, 400); `CHK("second setup", 3'h5, conv_ctrl.channel_sel)
        `CHK("latch second", 2'h1, latch)
        wait_sig(0, 400);
        rd(`ASCC_ADDR_STAT); `CHK("multi idle", 3'h0, rdv[2:0])
        done("multi setup");
        wr(`ASCC_ADDR_CFG, 32'h00030000);
        wr(`ASCC_ADDR_CMD, 32'h00000005);
        wait_sig(0, 400);
        rd(`ASCC_ADDR_STAT); `CHK("wait read", 3'h2, rdv[2:0])
        `CHK("pending set", 1'b1, data_pending)
        c = 0;
        repeat (400) begin @(posedge clk); if (conv_ctrl.start === 1'b1) c++; end
        `CHK("held off", 0, c)
        wr(`ASCC_ADDR_CMD, 32'h00000004);
        wait_sig(1, 20); `CHK("pending clr", 1'b0, data_pending)
        wait_sig(0, 400);
        wr(`ASCC_ADDR_CMD, 32'h00000002);
        rd(`ASCC_ADDR_STAT); `CHK("stopped", 3'h0, rdv[2:0])
        done("loop");
        osc_req <= 1'b1;
        repeat (8) @(posedge clk);
        rd(`ASCC_ADDR_CFG);  `CHK("osc set", 1'b1, rdv[5])
        osc_req <= 1'b0;
        repeat (8) @(posedge clk);
        rd(`ASCC_ADDR_CFG);  `CHK("osc clear", 1'b0, rdv[5])
        done("oscillation");
        wr(`ASCC_ADDR_CFG, 32'h00000200);
        rd(`ASCC_ADDR_STAT); `CHK("standby", 3'h3, rdv[2:0])
        `CHK("standby osc", 1'b1, conv_ctrl.osc_enable)
        `CHK("save", 1'b1, conv_ctrl.power_save)
        wr(`ASCC_ADDR_CFG, 32'h00000A00);
        rd(`ASCC_ADDR_STAT); `CHK("sleep osc", 1'b0, conv_ctrl.osc_enable)
        wr(`ASCC_ADDR_CFG, 32'h00000100);
        rd(`ASCC_ADDR_STAT); `CHK("wake", 3'h4, rdv[2:0])
        c = 0;
        do begin rd(`ASCC_ADDR_STAT); c++; end while (rdv[2:0] !== 3'h0 && c < 20);
        `CHK("run again", 3'h0, rdv[2:0])
        `CHK("low power", 1'b1, conv_ctrl.reduced_power)
        wr(`ASCC_ADDR_CFG, 32'h00200000);
        rd(`ASCC_ADDR_STAT); `CHK("chop sel", 2'h2, conv_ctrl.chop_rate_sel)
        @(posedge clk); ck = conv_ctrl.chop_clk;
        @(posedge clk); `CHK("chop toggle", ~ck, conv_ctrl.chop_clk)
        ck = pump_o;
        repeat (2) @(posedge clk); `CHK("pump toggle", ~ck, pump_o)
        done("power");
        rd(12'h0FC); `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, rdv)
        wr(`ASCC_ADDR_CFG, 32'h00000080);
        repeat (12) @(posedge clk);
        wr(`ASCC_ADDR_CFG, 32'h00000400);
        rd(`ASCC_ADDR_CFG);  `CHK("rs leave", 32'h00000040, rdv & 32'h000007C0)
        `CHK("pump kept", 1'b1, pump_oe)
        rd(`ASCC_ADDR_CFG);  `CHK("done read", 1'b0, rdv[6])
        rd(`ASCC_ADDR_CSR0); `CHK("csr sysreset", 32'h00000000, rdv)
        wr(`ASCC_ADDR_CFG, 32'h00000400);
        rd(`ASCC_ADDR_STAT); `CHK("pump off", 1'b0, pump_oe)
        ck = pump_o;
        repeat (2) @(posedge clk); `CHK("pump held", ck, pump_o)
        done("system reset");
        close_out();
    end
endmodule
